// *** hw/brc_regs.sv ***
// Baseband rate, line and serializer configuration registers with their derived controls
module brc_regs
   import brc_pkg::*;
#(
   parameter int CODE_W = 64
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic code_half_select,
   input wire logic [CODE_W-1:0] pn_code,
   input wire logic rx_raw,
   input wire logic tx_raw,
   input wire logic bit_tick,
   input wire logic bit_valid,
   input wire logic irq_req,
   output logic [6:0] chips_per_bit,
   output logic double_rate,
   output logic [1:0] bits_per_code,
   output logic [3:0] oversample,
   output logic dual_code_ok,
   output logic [CODE_W/2-1:0] code_a,
   output logic [CODE_W/2-1:0] code_b,
   output logic rx_data,
   output logic tx_data,
   output logic irq_o,
   output logic irq_oe_n,
   output logic byte_access_enable,
   output logic eof_event
);

   // Half code width
   localparam int HALF_W = CODE_W / 2;

   // Double rate is honoured only with 32-chip codes
   function automatic logic brc_eff_double(input logic [7:0] rate);
      brc_eff_double = rate[POS_CODE_WIDTH] & rate[POS_DATA_RATE];
   endfunction

   // Twelve-times sampling only in normal 32-chip mode
   function automatic logic brc_eff_os12(input logic [7:0] rate);
      brc_eff_os12 = rate[POS_CODE_WIDTH] & ~rate[POS_DATA_RATE] & rate[POS_SAMPLE_RATE];
   endfunction

   // Stored registers
   logic [7:0] chip_rate_setup; // Code width, rate, sampling
   logic [7:0] line_config; // Inversion and pin style
   logic [7:0] serializer_control; // Byte access and frame gap
   logic [7:0] next_chip_rate_setup;
   logic [7:0] next_line_config;
   logic [7:0] next_serializer_control;
   logic [DATA_W-1:0] next_reg_rdata;

   // Register writes and read data
   always_comb begin
      next_chip_rate_setup = chip_rate_setup;
      next_line_config = line_config;
      next_serializer_control = serializer_control;
      next_reg_rdata = '0;
      // Write: only implemented bits are kept
      if (reg_we) begin
         case (reg_addr)
            OFS_CHIP_RATE_SETUP: next_chip_rate_setup = reg_wdata & MASK_CHIP_RATE_SETUP;
            OFS_LINE_CONFIG: next_line_config = reg_wdata & MASK_LINE_CONFIG;
            OFS_SERIALIZER_CONTROL: begin
               next_serializer_control = reg_wdata & MASK_SERIALIZER_CONTROL;
            end
            default: begin
               // Unmapped write is dropped
            end
         endcase
      end
      // Read: unmapped address answers zero
      if (reg_re) begin
         case (reg_addr)
            OFS_CHIP_RATE_SETUP: next_reg_rdata = chip_rate_setup;
            OFS_LINE_CONFIG: next_reg_rdata = line_config;
            OFS_SERIALIZER_CONTROL: next_reg_rdata = serializer_control;
            default: next_reg_rdata = '0;
         endcase
      end
   end

   // Register storage
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         chip_rate_setup <= RST_CHIP_RATE_SETUP;
         line_config <= RST_LINE_CONFIG;
         serializer_control <= RST_SERIALIZER_CONTROL;
         reg_rdata <= '0;
      end else begin
         chip_rate_setup <= next_chip_rate_setup;
         line_config <= next_line_config;
         serializer_control <= next_serializer_control;
         reg_rdata <= next_reg_rdata;
      end
   end

   // Derived rate controls
   logic [6:0] next_chips_per_bit;
   logic next_double_rate;
   logic [1:0] next_bits_per_code;
   logic [3:0] next_oversample;
   logic next_dual_code_ok;
   logic [HALF_W-1:0] next_code_a;
   logic [HALF_W-1:0] next_code_b;
   logic [HALF_W-1:0] code_lo; // Lower chips of stored code
   logic [HALF_W-1:0] code_hi; // Upper chips of stored code

   // Code, rate and sampling decode
   always_comb begin
      code_lo = pn_code[HALF_W-1:0];
      code_hi = pn_code[CODE_W-1:HALF_W];
      next_chips_per_bit = chip_rate_setup[POS_CODE_WIDTH] ? CHIPS_32 : CHIPS_64;
      next_double_rate = brc_eff_double(chip_rate_setup);
      next_bits_per_code = next_double_rate ? BITS_TWO : BITS_ONE;
      next_oversample = brc_eff_os12(chip_rate_setup) ? OS_12X : OS_6X;
      // Second code only in normal 32-chip mode at six times
      next_dual_code_ok = chip_rate_setup[POS_CODE_WIDTH] & ~next_double_rate
         & ~brc_eff_os12(chip_rate_setup);
      if (!chip_rate_setup[POS_CODE_WIDTH]) begin
         // Full 64-chip code, low half on a
         next_code_a = code_lo;
         next_code_b = code_hi;
      end else if (next_double_rate) begin
         // Two halves encode two bits per symbol
         next_code_a = code_lo;
         next_code_b = code_hi;
      end else if (code_half_select) begin
         // Upper half primary, lower half second code
         next_code_a = code_hi;
         next_code_b = code_lo;
      end else begin
         // Lower half primary, upper half second code
         next_code_a = code_lo;
         next_code_b = code_hi;
      end
   end

   // Rate control registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         chips_per_bit <= CHIPS_64;
         double_rate <= 1'b0;
         bits_per_code <= BITS_ONE;
         oversample <= OS_6X;
         dual_code_ok <= 1'b0;
         code_a <= '0;
         code_b <= '0;
      end else begin
         chips_per_bit <= next_chips_per_bit;
         double_rate <= next_double_rate;
         bits_per_code <= next_bits_per_code;
         oversample <= next_oversample;
         dual_code_ok <= next_dual_code_ok;
         code_a <= next_code_a;
         code_b <= next_code_b;
      end
   end

   // Data line and interrupt pin
   logic next_rx_data;
   logic next_tx_data;
   logic next_irq_o;
   logic next_irq_oe_n;
   logic next_byte_access_enable;
   logic [1:0] irq_style; // Pin drive style field

   // Inversion and pin drive decode
   always_comb begin
      irq_style = line_config[POS_IRQ_STYLE +: 2];
      next_rx_data = rx_raw ^ line_config[POS_RX_INVERT];
      next_tx_data = tx_raw ^ line_config[POS_TX_INVERT];
      next_byte_access_enable = serializer_control[POS_BYTE_ACCESS];
      case (irq_style)
         // Pull low when asserted, else released
         IRQ_OPEN_DRAIN: begin
            next_irq_o = 1'b0;
            next_irq_oe_n = ~irq_req;
         end
         // Drive high when asserted, else released
         IRQ_OPEN_SOURCE: begin
            next_irq_o = 1'b1;
            next_irq_oe_n = ~irq_req;
         end
         // Always driven, high when asserted
         IRQ_PUSH_PULL: begin
            next_irq_o = irq_req;
            next_irq_oe_n = 1'b0;
         end
         // Always driven, low when asserted
         default: begin
            next_irq_o = ~irq_req;
            next_irq_oe_n = 1'b0;
         end
      endcase
   end

   // Line and pin registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_data <= 1'b0;
         tx_data <= 1'b0;
         irq_o <= 1'b0;
         irq_oe_n <= 1'b0;
         byte_access_enable <= 1'b0;
      end else begin
         rx_data <= next_rx_data;
         tx_data <= next_tx_data;
         irq_o <= next_irq_o;
         irq_oe_n <= next_irq_oe_n;
         byte_access_enable <= next_byte_access_enable;
      end
   end

   // End-of-frame gap counter
   logic eof_armed; // A valid bit seen since last event
   logic [EOF_LEN_W-1:0] eof_cnt; // Invalid bits counted so far
   logic next_eof_armed;
   logic [EOF_LEN_W-1:0] next_eof_cnt;
   logic next_eof_event;
   logic [EOF_LEN_W-1:0] eof_len; // Programmed gap length

   // Count invalid bit times after a valid reception
   always_comb begin
      eof_len = serializer_control[POS_EOF_LEN +: EOF_LEN_W];
      next_eof_armed = eof_armed;
      next_eof_cnt = eof_cnt;
      next_eof_event = 1'b0;
      if (bit_tick) begin
         if (bit_valid) begin
            // Valid bit restarts the gap
            next_eof_armed = 1'b1;
            next_eof_cnt = '0;
         end else if (eof_armed) begin
            if (eof_cnt >= eof_len) begin // Also ends a frame if the length shrank
               // Gap exceeded: raise event once
               next_eof_event = 1'b1;
               next_eof_armed = 1'b0;
               next_eof_cnt = '0;
            end else begin
               next_eof_cnt = eof_cnt + 1'b1;
            end
         end
      end
   end

   // Gap counter registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         eof_armed <= 1'b0;
         eof_cnt <= '0;
         eof_event <= 1'b0;
      end else begin
         eof_armed <= next_eof_armed;
         eof_cnt <= next_eof_cnt;
         eof_event <= next_eof_event;
      end
   end

   // Checks on derived outputs
   a_chip_width: assert property (@(posedge clk) disable iff (!resetn)
      reg_we && reg_addr == OFS_CHIP_RATE_SETUP
      ##1 !(reg_we && reg_addr == OFS_CHIP_RATE_SETUP) |=>
      chips_per_bit == ($past(reg_wdata[POS_CODE_WIDTH], 2) ? CHIPS_32 : CHIPS_64))
      else $error("chip width does not follow written bit");
   a_double_gate: assert property (@(posedge clk) disable iff (!resetn)
      double_rate |-> chips_per_bit == CHIPS_32 && bits_per_code == BITS_TWO)
      else $error("double rate without 32-chip codes");
   a_rate_bits: assert property (@(posedge clk) disable iff (!resetn)
      chip_rate_setup[POS_CODE_WIDTH] && chip_rate_setup[POS_DATA_RATE] |=> double_rate)
      else $error("double rate not taken");
   a_os_ignore: assert property (@(posedge clk) disable iff (!resetn)
      !chip_rate_setup[POS_CODE_WIDTH] || chip_rate_setup[POS_DATA_RATE] |=> oversample == OS_6X)
      else $error("sampling not forced to six times");
   a_os_twelve: assert property (@(posedge clk) disable iff (!resetn)
      chip_rate_setup[2:0] == 3'h5 |=> oversample == OS_12X)
      else $error("twelve times sampling not taken");
   a_single_code: assert property (@(posedge clk) disable iff (!resetn)
      oversample == OS_12X |-> !dual_code_ok)
      else $error("two codes allowed at twelve times");
   a_dual_code: assert property (@(posedge clk) disable iff (!resetn)
      chip_rate_setup[2:0] == 3'h4 |=> dual_code_ok && bits_per_code == BITS_ONE)
      else $error("normal 32-chip mode lacks second code");
   a_half_split: assert property (@(posedge clk) disable iff (!resetn)
      double_rate |-> code_a == $past(pn_code[HALF_W-1:0])
      && code_b == $past(pn_code[CODE_W-1:HALF_W]))
      else $error("double rate halves wrong");
   a_half_select: assert property (@(posedge clk) disable iff (!resetn)
      chip_rate_setup[2:0] == 3'h4 && code_half_select |=> code_a == $past(pn_code[CODE_W-1:HALF_W]))
      else $error("upper half not selected");
   a_rx_invert: assert property (@(posedge clk) disable iff (!resetn)
      1'b1 |=> rx_data == ($past(rx_raw) ^ $past(line_config[POS_RX_INVERT])))
      else $error("receive data inversion wrong");
   a_tx_invert: assert property (@(posedge clk) disable iff (!resetn)
      1'b1 |=> tx_data == ($past(tx_raw) ^ $past(line_config[POS_TX_INVERT])))
      else $error("transmit data inversion wrong");
   a_irq_drain: assert property (@(posedge clk) disable iff (!resetn)
      line_config[1:0] == IRQ_OPEN_DRAIN |=> irq_o == 1'b0 && irq_oe_n == !$past(irq_req))
      else $error("open drain pin drive wrong");
   a_byte_access: assert property (@(posedge clk) disable iff (!resetn)
      1'b1 |=> byte_access_enable == $past(serializer_control[POS_BYTE_ACCESS]))
      else $error("byte access select wrong");
   a_eof_first: assert property (@(posedge clk) disable iff (!resetn)
      bit_tick && !bit_valid && eof_armed && eof_len == 3'h0 |=> eof_event)
      else $error("zero length gap missed first invalid bit");
   a_eof_cause: assert property (@(posedge clk) disable iff (!resetn)
      eof_event |-> $past(bit_tick && !bit_valid && eof_armed))
      else $error("end of frame without invalid bit");

endmodule

// *** hw/brc_pkg.sv ***
// Constants, field layout and reset values of the baseband rate configuration registers
// Function
// - Code width bit picks 32 or 64 chips
// - Rate bit set carries two bits per code
// - Double rate only with 32-chip codes
// - Double rate splits 64-chip code into halves
// - Normal 32-chip rate allows two codes
// - Oversampling bit picks twelve or six times
// - Oversampling forced six times unless normal 32-chip
// - Twelve times allows only one code
// - Receive invert bit inverts received data
// - Transmit invert bit inverts transmitted data
// - Two-bit field sets interrupt pin drive style
// - Half select picks upper or lower 32 chips at normal 32-chip rate
// - Byte access bit selects byte or serial access
// - End-of-frame after length invalid bits, zero first
package brc_pkg;
   // Register port widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   // Register offsets
   localparam logic [7:0] OFS_CHIP_RATE_SETUP = 8'h04;
   localparam logic [7:0] OFS_LINE_CONFIG = 8'h05;
   localparam logic [7:0] OFS_SERIALIZER_CONTROL = 8'h06;
   // Reset values
   localparam logic [7:0] RST_CHIP_RATE_SETUP = 8'h00;
   localparam logic [7:0] RST_LINE_CONFIG = 8'h01;
   localparam logic [7:0] RST_SERIALIZER_CONTROL = 8'h03;
   // Implemented bits; reserved bits read as zero
   localparam logic [7:0] MASK_CHIP_RATE_SETUP = 8'h07;
   localparam logic [7:0] MASK_LINE_CONFIG = 8'h1b;
   localparam logic [7:0] MASK_SERIALIZER_CONTROL = 8'h0f;
   // Field positions of chip_rate_setup
   localparam int POS_CODE_WIDTH = 2;
   localparam int POS_DATA_RATE = 1;
   localparam int POS_SAMPLE_RATE = 0;
   // Field positions of line_config
   localparam int POS_RX_INVERT = 4;
   localparam int POS_TX_INVERT = 3;
   localparam int POS_IRQ_STYLE = 0;
   // Field positions of serializer_control
   localparam int POS_BYTE_ACCESS = 3;
   localparam int POS_EOF_LEN = 0;
   localparam int EOF_LEN_W = 3;
   // Interrupt pin drive styles
   localparam logic [1:0] IRQ_OPEN_DRAIN = 2'h3;
   localparam logic [1:0] IRQ_OPEN_SOURCE = 2'h2;
   localparam logic [1:0] IRQ_PUSH_PULL = 2'h1;
   localparam logic [1:0] IRQ_PUSH_PULL_INV = 2'h0;
   // Derived operating figures
   localparam logic [6:0] CHIPS_32 = 7'h20;
   localparam logic [6:0] CHIPS_64 = 7'h40;
   localparam logic [3:0] OS_6X = 4'h6;
   localparam logic [3:0] OS_12X = 4'hc;
   localparam logic [1:0] BITS_ONE = 2'h1;
   localparam logic [1:0] BITS_TWO = 2'h2;
endpackage

// *** verif/brc_host.sv ***
// Host model that drives the configuration register port
module brc_host
   import brc_pkg::*;
(
   input wire logic clk,
   output logic [ADDR_W-1:0] reg_addr,
   output logic [DATA_W-1:0] reg_wdata,
   output logic reg_we,
   output logic reg_re,
   input wire logic [DATA_W-1:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 100ps;

   // Idle port at time zero
   initial begin
      reg_addr = '0;
      reg_wdata = '0;
      reg_we = 1'b0;
      reg_re = 1'b0;
   end

   // One write strobe; released lines show the inverse of the last value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] m;
      m = (a == OFS_CHIP_RATE_SETUP) ? MASK_CHIP_RATE_SETUP :
         (a == OFS_LINE_CONFIG) ? MASK_LINE_CONFIG :
         (a == OFS_SERIALIZER_CONTROL) ? MASK_SERIALIZER_CONTROL : 8'hff;
      // Invalid rate settings are never sent
      if (a == OFS_CHIP_RATE_SETUP && d[2:0] inside {3'h1, 3'h2, 3'h3}) begin
         return;
      end
      @(negedge clk);
      reg_addr <= a;
      reg_wdata <= d & m;
      reg_we <= 1'b1;
      @(negedge clk);
      reg_we <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~(d & m);
   endtask

   // One read strobe; data taken in the cycle after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr <= a;
      reg_re <= 1'b1;
      @(negedge clk);
      d = reg_rdata;
      reg_re <= 1'b0;
      reg_addr <= ~a;
   endtask
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the baseband rate configuration registers
module testbench
   import brc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // Design connections
   logic clk, resetn, code_half_select, rx_raw, tx_raw, bit_tick, bit_valid, irq_req;
   logic [63:0] pn_code;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic reg_we, reg_re, double_rate, dual_code_ok, rx_data, tx_data;
   logic irq_o, irq_oe_n, byte_access_enable, eof_event;
   logic [6:0] chips_per_bit;
   logic [1:0] bits_per_code;
   logic [3:0] oversample;
   logic [31:0] code_a, code_b;
   int miscompares, checks_done, cycles;

   brc_regs u_brc_regs (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
      .code_half_select(code_half_select), .pn_code(pn_code), .rx_raw(rx_raw),
      .tx_raw(tx_raw), .bit_tick(bit_tick), .bit_valid(bit_valid), .irq_req(irq_req),
      .chips_per_bit(chips_per_bit), .double_rate(double_rate),
      .bits_per_code(bits_per_code), .oversample(oversample), .dual_code_ok(dual_code_ok),
      .code_a(code_a), .code_b(code_b), .rx_data(rx_data), .tx_data(tx_data),
      .irq_o(irq_o), .irq_oe_n(irq_oe_n), .byte_access_enable(byte_access_enable),
      .eof_event(eof_event));

   brc_host u_brc_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata));

   // Free-running 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Verdict and end of run
   task automatic end_sim;
      if (miscompares == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Register data compare
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t register %h expected %h", $time, got, exp);
      end
   endtask

   // Derived signal compare
   task automatic chk_sig(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t signal %h expected %h", $time, got, exp);
      end
   endtask

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         miscompares++;
         $display("ERROR %0t timeout", $time);
         end_sim();
      end
   end

   // Reset values, unmapped read and decoded defaults
   task automatic t_reset;
      logic [7:0] d;
      u_brc_host.rd(OFS_CHIP_RATE_SETUP, d);
      chk_reg(d, 8'h00);
      u_brc_host.rd(OFS_LINE_CONFIG, d);
      chk_reg(d, 8'h01);
      u_brc_host.rd(OFS_SERIALIZER_CONTROL, d);
      chk_reg(d, 8'h03);
      u_brc_host.rd(8'h07, d);
      chk_reg(d, 8'h00);
      chk_sig(chips_per_bit, 32'd64);
      chk_sig(oversample, 32'd6);
      chk_sig(byte_access_enable, 32'd0);
   endtask

   // Every legal rate setting with both code halves
   task automatic t_modes;
      logic [2:0] s [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
      logic [7:0] d;
      logic w32, dr, os, sel;
      for (int i = 0; i < 5; i++) begin
         for (int h = 0; h < 2; h++) begin
            code_half_select = h[0];
            u_brc_host.wr(OFS_CHIP_RATE_SETUP, {5'h00, s[i]});
            repeat (2) @(negedge clk);
            w32 = s[i][2];
            dr = w32 & s[i][1];
            os = w32 & ~dr & s[i][0];
            sel = w32 & ~dr & h[0];
            chk_sig(chips_per_bit, w32 ? 32'd32 : 32'd64);
            chk_sig(double_rate, dr);
            chk_sig(bits_per_code, dr ? 32'd2 : 32'd1);
            chk_sig(oversample, os ? 32'd12 : 32'd6);
            chk_sig(dual_code_ok, w32 & ~dr & ~os);
            chk_sig(code_a, sel ? pn_code[63:32] : pn_code[31:0]);
            chk_sig(code_b, sel ? pn_code[31:0] : pn_code[63:32]);
            u_brc_host.rd(OFS_CHIP_RATE_SETUP, d);
            chk_reg(d, {5'h00, s[i]});
         end
      end
   endtask

   // Data inversion and every interrupt pin style
   task automatic t_line;
      logic inv, r, o;
      for (int st = 0; st < 4; st++) begin
         inv = st[0];
         u_brc_host.wr(OFS_LINE_CONFIG, {3'h0, inv, ~inv, 1'b0, st[1:0]});
         for (int k = 0; k < 2; k++) begin
            r = k[0];
            irq_req = r;
            rx_raw = r;
            tx_raw = ~r;
            repeat (2) @(negedge clk);
            o = (st == 3) ? 1'b0 : (st == 2) ? 1'b1 : (st == 1) ? r : ~r;
            chk_sig(rx_data, r ^ inv);
            chk_sig(tx_data, r ^ inv);
            chk_sig(irq_o, o);
            chk_sig(irq_oe_n, st[1] & ~r);
         end
      end
   endtask

   // One bit time; end-of-frame pulse judged in the following cycle
   task automatic tick(input logic v, input logic exp);
      bit_tick = 1'b1;
      bit_valid = v;
      @(negedge clk);
      bit_tick = 1'b0;
      chk_sig(eof_event, exp);
      @(negedge clk);
   endtask

   // Byte access mode and end-of-frame counting for lengths 2 and 0
   task automatic t_eof;
      u_brc_host.wr(OFS_SERIALIZER_CONTROL, 8'h0a);
      repeat (2) @(negedge clk);
      chk_sig(byte_access_enable, 32'd1);
      tick(1'b0, 1'b0);
      tick(1'b1, 1'b0);
      tick(1'b0, 1'b0);
      tick(1'b0, 1'b0);
      tick(1'b0, 1'b1);
      u_brc_host.wr(OFS_SERIALIZER_CONTROL, 8'h00);
      repeat (2) @(negedge clk);
      chk_sig(byte_access_enable, 32'd0);
      tick(1'b1, 1'b0);
      tick(1'b0, 1'b1);
      tick(1'b0, 1'b0);
   endtask

   // Main sequence
   initial begin
      resetn = 1'b0;
      code_half_select = 1'b0;
      pn_code = 64'h0123456789abcdef;
      rx_raw = 1'b0;
      tx_raw = 1'b0;
      bit_tick = 1'b0;
      bit_valid = 1'b0;
      irq_req = 1'b0;
      repeat (20) @(negedge clk);
      resetn = 1'b1;
      t_reset();
      t_modes();
      t_line();
      t_eof();
      end_sim();
   end
endmodule
